// ===== hdl/xfer_pkg.sv
`default_nettype none
package xfer_pkg;
  // timebase
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned TICK_PERIOD_NS = 100_000_000;
  localparam int unsigned TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned DLY_W = 12;
  localparam int unsigned LVL_W = 10;
  // register offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_AUD_CHG_DLY = 8'h04;
  localparam logic [7:0] OFF_AUD_RET_DLY = 8'h08;
  localparam logic [7:0] OFF_AUD_CHG_LVL = 8'h0c;
  localparam logic [7:0] OFF_AUD_RET_LVL = 8'h10;
  localparam logic [7:0] OFF_RF_CHG_DLY = 8'h14;
  localparam logic [7:0] OFF_STATUS = 8'h18;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h1c;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h20;
  // control field positions
  localparam int unsigned CTRL_AUDIO_AUTO = 0;
  localparam int unsigned CTRL_AUDIO_BACKUP = 1;
  localparam int unsigned CTRL_MAINT = 2;
  localparam int unsigned CTRL_RF_ON = 3;
  localparam int unsigned CTRL_RF_AUTO = 4;
  localparam int unsigned CTRL_ACTIVE_TX2 = 5;
  localparam int unsigned CTRL_W = 6;
  localparam logic [5:0] CTRL_RST = 6'h11;
  // delays in 0.1 s ticks, levels in 0.1 db below full scale
  localparam logic [11:0] DLY_DEFAULT = 12'hbb8;
  localparam logic [11:0] DLY_MAX = 12'hbb8;
  localparam logic [11:0] AUD_DLY_MIN = 12'h001;
  localparam logic [11:0] RF_DLY_MIN = 12'h046;
  localparam logic [9:0] LVL_DEFAULT = 10'h258;
  localparam logic [9:0] LVL_MIN = 10'h001;
  localparam logic [9:0] LVL_MAX = 10'h258;
  // interrupt bits
  localparam int unsigned IRQ_AUD_BACKUP = 0;
  localparam int unsigned IRQ_AUD_MAIN = 1;
  localparam int unsigned IRQ_RF_XFER = 2;
  localparam int unsigned IRQ_REJECT = 3;
  localparam int unsigned IRQ_W = 4;
  localparam logic [3:0] IRQ_MASK_RST = 4'h0;
  typedef enum logic {AUD_MAIN = 1'b0, AUD_BACKUP = 1'b1} audio_src_e;
endpackage
`default_nettype wire

// ===== hdl/tick_gen.sv
`timescale 1ns/1ps
`default_nettype none
module tick_gen #(
  parameter int unsigned CYCLES = xfer_pkg::TICK_CYCLES
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // one-cycle pulse per period
  output logic tick
);
  localparam int unsigned W = (CYCLES > 1) ? $clog2(CYCLES) : 1;
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  logic tick_r;
  logic tick_nxt;

  // free running divider
  always_comb
  begin
    tick_nxt = (cnt_r == W'(CYCLES - 1));
    cnt_nxt = tick_nxt ? '0 : cnt_r + 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_r <= '0;
      tick_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick = tick_r;
endmodule // tick_gen
`default_nettype wire

// ===== hdl/qual_timer.sv
`timescale 1ns/1ps
`default_nettype none
module qual_timer #(
  parameter int unsigned W = xfer_pkg::DLY_W
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // timebase and condition
  input wire logic tick,
  input wire logic cond,
  input wire logic [W-1:0] limit,
  // condition held for limit ticks
  output logic expired
);
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  logic exp_r;
  logic exp_nxt;

  // restarts whenever the condition drops, saturates at the limit
  always_comb
  begin
    if (!cond)
      cnt_nxt = '0;
    else if (tick && cnt_r < limit)
      cnt_nxt = cnt_r + 1'b1;
    else
      cnt_nxt = cnt_r;
    exp_nxt = cond && (cnt_nxt >= limit);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_r <= '0;
      exp_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      exp_r <= exp_nxt;
    end
  end

  assign expired = exp_r;
endmodule // qual_timer
`default_nettype wire

// ===== hdl/transmitter_transfer_control.sv
// Summary of operation
// - auto audio: main until low past delay
// - auto: back to main after return delay
// - manual audio: selected source, no changeover
// - normal mode: standby muted, auto rf allowed
// - maintenance: standby on only with interlocks
// - maintenance blocks automatic rf changeover
// - rf on: on-air enabled, standby conditional
// - rf off: both transmitters muted
// - rf controlled by mute commands only
// - audio delay 0.1 to 300 s, default 300
// - audio delay ignored in manual mode
// - remote audio mode equals local button
// - remote rf on/off equals local button
// - return level not below changeover level
// - rf delay 7 to 300 s, reject others
// - auto rf: transfer when main low past delay
//
// The implementer's own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module transmitter_transfer_control #(
  parameter int unsigned TICK_CYCLES = xfer_pkg::TICK_CYCLES
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // front panel buttons, one-cycle pulses
  input wire logic btn_audio_auto,
  input wire logic btn_audio_manual,
  input wire logic btn_rf_on,
  input wire logic btn_rf_off,
  // measurements and interlocks
  input wire logic [9:0] main_audio_atten,
  input wire logic main_rf_low,
  input wire logic sys_interlock_ok,
  input wire logic dummy_interlock_ok,
  // outputs
  output logic tx1_mute,
  output logic tx2_mute,
  output logic audio_backup_sel,
  output logic irq
);
  function automatic logic in_range(input logic [11:0] v, input logic [11:0] lo,
                                    input logic [11:0] hi);
    in_range = (v >= lo) && (v <= hi);
  endfunction

  logic tick;
  logic aud_chg_exp;
  logic aud_ret_exp;
  logic rf_exp;
  logic [5:0] ctrl_r, ctrl_nxt;
  logic [11:0] aud_chg_dly_r, aud_chg_dly_nxt;
  logic [11:0] aud_ret_dly_r, aud_ret_dly_nxt;
  logic [11:0] rf_dly_r, rf_dly_nxt;
  logic [9:0] chg_lvl_r, chg_lvl_nxt;
  logic [9:0] ret_lvl_r, ret_lvl_nxt;
  logic [3:0] irq_stat_r, irq_stat_nxt;
  logic [3:0] irq_mask_r, irq_mask_nxt;
  xfer_pkg::audio_src_e aud_r, aud_nxt;
  logic xfer_r, xfer_nxt;
  logic tx1_mute_r, tx1_mute_nxt;
  logic tx2_mute_r, tx2_mute_nxt;
  logic irq_r, irq_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;
  logic wr;
  logic hit;
  logic reject;
  logic [3:0] ev;
  logic onair_tx2;
  logic onair_mute;
  logic standby_mute;

  tick_gen #(.CYCLES(TICK_CYCLES)) u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick)
  );

  // audio changeover qualified only in auto mode on main
  qual_timer #(.W(xfer_pkg::DLY_W)) u_aud_chg (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick),
    .cond(ctrl_r[xfer_pkg::CTRL_AUDIO_AUTO] && aud_r == xfer_pkg::AUD_MAIN
          && main_audio_atten > chg_lvl_r),
    .limit(aud_chg_dly_r),
    .expired(aud_chg_exp)
  );

  qual_timer #(.W(xfer_pkg::DLY_W)) u_aud_ret (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick),
    .cond(ctrl_r[xfer_pkg::CTRL_AUDIO_AUTO] && aud_r == xfer_pkg::AUD_BACKUP
          && main_audio_atten < ret_lvl_r),
    .limit(aud_ret_dly_r),
    .expired(aud_ret_exp)
  );

  // maintenance and rf off both hold the rf timer in restart
  qual_timer #(.W(xfer_pkg::DLY_W)) u_rf (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick),
    .cond(ctrl_r[xfer_pkg::CTRL_RF_AUTO] && !ctrl_r[xfer_pkg::CTRL_MAINT]
          && ctrl_r[xfer_pkg::CTRL_RF_ON] && !xfer_r && main_rf_low),
    .limit(rf_dly_r),
    .expired(rf_exp)
  );

  // apb: setup cycle loads answer, access cycle has pready high
  assign wr = psel && penable && pready_r && pwrite;
  always_comb
  begin
    hit = 1'b1;
    case (paddr)
      xfer_pkg::OFF_CTRL: prdata_nxt = {26'h0, ctrl_r};
      xfer_pkg::OFF_AUD_CHG_DLY: prdata_nxt = {20'h0, aud_chg_dly_r};
      xfer_pkg::OFF_AUD_RET_DLY: prdata_nxt = {20'h0, aud_ret_dly_r};
      xfer_pkg::OFF_AUD_CHG_LVL: prdata_nxt = {22'h0, chg_lvl_r};
      xfer_pkg::OFF_AUD_RET_LVL: prdata_nxt = {22'h0, ret_lvl_r};
      xfer_pkg::OFF_RF_CHG_DLY: prdata_nxt = {20'h0, rf_dly_r};
      xfer_pkg::OFF_STATUS: prdata_nxt = {26'h0, dummy_interlock_ok, sys_interlock_ok,
                                          tx2_mute_r, tx1_mute_r, onair_tx2, aud_r};
      xfer_pkg::OFF_IRQ_STAT: prdata_nxt = {28'h0, irq_stat_r};
      xfer_pkg::OFF_IRQ_MASK: prdata_nxt = {28'h0, irq_mask_r};
      default:
      begin
        prdata_nxt = 32'h0;
        hit = 1'b0;
      end
    endcase
    pready_nxt = psel && !penable;
    pslverr_nxt = pready_nxt && !hit;
  end

  // settings registers; out-of-range values keep the old setting
  always_comb
  begin
    ctrl_nxt = ctrl_r;
    aud_chg_dly_nxt = aud_chg_dly_r;
    aud_ret_dly_nxt = aud_ret_dly_r;
    rf_dly_nxt = rf_dly_r;
    chg_lvl_nxt = chg_lvl_r;
    ret_lvl_nxt = ret_lvl_r;
    irq_mask_nxt = irq_mask_r;
    reject = 1'b0;
    if (wr)
    begin
      case (paddr)
        xfer_pkg::OFF_CTRL: ctrl_nxt = pwdata[5:0];
        xfer_pkg::OFF_AUD_CHG_DLY:
          if (in_range(pwdata[11:0], xfer_pkg::AUD_DLY_MIN, xfer_pkg::DLY_MAX)
              && pwdata[31:12] == 20'h0)
            aud_chg_dly_nxt = pwdata[11:0];
          else
            reject = 1'b1;
        xfer_pkg::OFF_AUD_RET_DLY:
          if (in_range(pwdata[11:0], xfer_pkg::AUD_DLY_MIN, xfer_pkg::DLY_MAX)
              && pwdata[31:12] == 20'h0)
            aud_ret_dly_nxt = pwdata[11:0];
          else
            reject = 1'b1;
        xfer_pkg::OFF_RF_CHG_DLY:
          if (in_range(pwdata[11:0], xfer_pkg::RF_DLY_MIN, xfer_pkg::DLY_MAX)
              && pwdata[31:12] == 20'h0)
            rf_dly_nxt = pwdata[11:0];
          else
            reject = 1'b1;
        // less attenuation means more amplitude
        xfer_pkg::OFF_AUD_CHG_LVL:
          if (in_range({2'b0, pwdata[9:0]}, {2'b0, xfer_pkg::LVL_MIN}, {2'b0, xfer_pkg::LVL_MAX})
              && pwdata[31:10] == 22'h0 && ret_lvl_r <= pwdata[9:0])
            chg_lvl_nxt = pwdata[9:0];
          else
            reject = 1'b1;
        xfer_pkg::OFF_AUD_RET_LVL:
          if (in_range({2'b0, pwdata[9:0]}, {2'b0, xfer_pkg::LVL_MIN}, {2'b0, xfer_pkg::LVL_MAX})
              && pwdata[31:10] == 22'h0 && pwdata[9:0] <= chg_lvl_r)
            ret_lvl_nxt = pwdata[9:0];
          else
            reject = 1'b1;
        xfer_pkg::OFF_IRQ_MASK: irq_mask_nxt = pwdata[3:0];
        default: reject = 1'b0;
      endcase
    end
    // a button acts on its own field just like a remote write
    if (btn_audio_auto)
      ctrl_nxt[xfer_pkg::CTRL_AUDIO_AUTO] = 1'b1;
    if (btn_audio_manual)
      ctrl_nxt[xfer_pkg::CTRL_AUDIO_AUTO] = 1'b0;
    if (btn_rf_on)
      ctrl_nxt[xfer_pkg::CTRL_RF_ON] = 1'b1;
    if (btn_rf_off)
      ctrl_nxt[xfer_pkg::CTRL_RF_ON] = 1'b0;
  end

  // audio source and rf transfer state
  always_comb
  begin
    aud_nxt = aud_r;
    ev = 4'h0;
    if (!ctrl_r[xfer_pkg::CTRL_AUDIO_AUTO])
      aud_nxt = xfer_pkg::audio_src_e'(ctrl_r[xfer_pkg::CTRL_AUDIO_BACKUP]);
    else
      case (aud_r)
        xfer_pkg::AUD_MAIN:
          if (aud_chg_exp)
          begin
            aud_nxt = xfer_pkg::AUD_BACKUP;
            ev[xfer_pkg::IRQ_AUD_BACKUP] = 1'b1;
          end
        xfer_pkg::AUD_BACKUP:
          if (aud_ret_exp)
          begin
            aud_nxt = xfer_pkg::AUD_MAIN;
            ev[xfer_pkg::IRQ_AUD_MAIN] = 1'b1;
          end
        default: aud_nxt = xfer_pkg::AUD_MAIN;
      endcase
    // new active transmitter selection cancels a transfer
    if (wr && paddr == xfer_pkg::OFF_CTRL
        && pwdata[xfer_pkg::CTRL_ACTIVE_TX2] != ctrl_r[xfer_pkg::CTRL_ACTIVE_TX2])
      xfer_nxt = 1'b0;
    else
      xfer_nxt = xfer_r || (rf_exp && !ctrl_r[xfer_pkg::CTRL_MAINT]);
    // timer output lags a cycle, so maintenance gates the transfer itself too
    ev[xfer_pkg::IRQ_RF_XFER] = rf_exp && !xfer_r && !ctrl_r[xfer_pkg::CTRL_MAINT];
    ev[xfer_pkg::IRQ_REJECT] = reject;
  end

  // mute commands; standby stays inhibited outside maintenance
  assign onair_tx2 = ctrl_r[xfer_pkg::CTRL_ACTIVE_TX2] ^ xfer_r;
  assign onair_mute = !ctrl_r[xfer_pkg::CTRL_RF_ON];
  assign standby_mute = !(ctrl_r[xfer_pkg::CTRL_RF_ON] && ctrl_r[xfer_pkg::CTRL_MAINT]
                          && sys_interlock_ok && dummy_interlock_ok);
  always_comb
  begin
    tx1_mute_nxt = onair_tx2 ? standby_mute : onair_mute;
    tx2_mute_nxt = onair_tx2 ? onair_mute : standby_mute;
    // set wins over a same-cycle write-one clear
    irq_stat_nxt = irq_stat_r;
    if (wr && paddr == xfer_pkg::OFF_IRQ_STAT)
      irq_stat_nxt = irq_stat_r & ~pwdata[3:0];
    irq_stat_nxt = irq_stat_nxt | ev;
    irq_nxt = |(irq_stat_nxt & irq_mask_nxt);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_r <= xfer_pkg::CTRL_RST;
      aud_chg_dly_r <= xfer_pkg::DLY_DEFAULT;
      aud_ret_dly_r <= xfer_pkg::DLY_DEFAULT;
      rf_dly_r <= xfer_pkg::DLY_DEFAULT;
      chg_lvl_r <= xfer_pkg::LVL_DEFAULT;
      ret_lvl_r <= xfer_pkg::LVL_DEFAULT;
      irq_stat_r <= 4'h0;
      irq_mask_r <= xfer_pkg::IRQ_MASK_RST;
      aud_r <= xfer_pkg::AUD_MAIN;
      xfer_r <= 1'b0;
      tx1_mute_r <= 1'b1;
      tx2_mute_r <= 1'b1;
      irq_r <= 1'b0;
      prdata_r <= 32'h0;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
      aud_chg_dly_r <= aud_chg_dly_nxt;
      aud_ret_dly_r <= aud_ret_dly_nxt;
      rf_dly_r <= rf_dly_nxt;
      chg_lvl_r <= chg_lvl_nxt;
      ret_lvl_r <= ret_lvl_nxt;
      irq_stat_r <= irq_stat_nxt;
      irq_mask_r <= irq_mask_nxt;
      aud_r <= aud_nxt;
      xfer_r <= xfer_nxt;
      tx1_mute_r <= tx1_mute_nxt;
      tx2_mute_r <= tx2_mute_nxt;
      irq_r <= irq_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign tx1_mute = tx1_mute_r;
  assign tx2_mute = tx2_mute_r;
  assign audio_backup_sel = aud_r;
  assign irq = irq_r;

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_rf_off;
    !ctrl_r[xfer_pkg::CTRL_RF_ON] |=> tx1_mute_r && tx2_mute_r;
  endproperty
  a_rf_off: assert property (p_rf_off) else $error("rf off but a transmitter unmuted");

  property p_standby_gate;
    ($past(onair_tx2) ? !tx1_mute_r : !tx2_mute_r) |-> $past(ctrl_r[xfer_pkg::CTRL_MAINT]
      && sys_interlock_ok && dummy_interlock_ok);
  endproperty
  a_standby_gate: assert property (p_standby_gate) else $error("standby unmuted illegally");

  property p_onair_on;
    ctrl_r[xfer_pkg::CTRL_RF_ON] |=> ($past(onair_tx2) ? !tx2_mute_r : !tx1_mute_r);
  endproperty
  a_onair_on: assert property (p_onair_on) else $error("on-air transmitter muted with rf on");

  property p_maint_no_xfer;
    ctrl_r[xfer_pkg::CTRL_MAINT] |=> !$rose(xfer_r);
  endproperty
  a_maint_no_xfer: assert property (p_maint_no_xfer) else $error("rf transfer in maintenance");

  property p_manual;
    !ctrl_r[xfer_pkg::CTRL_AUDIO_AUTO] |=> aud_r == $past(ctrl_r[xfer_pkg::CTRL_AUDIO_BACKUP]);
  endproperty
  a_manual: assert property (p_manual) else $error("manual audio not following selection");

  property p_to_backup;
    $rose(aud_r) && $past(ctrl_r[xfer_pkg::CTRL_AUDIO_AUTO]) |-> $past(aud_chg_exp);
  endproperty
  a_to_backup: assert property (p_to_backup) else $error("audio changed over unqualified");

  property p_to_main;
    $fell(aud_r) && $past(ctrl_r[xfer_pkg::CTRL_AUDIO_AUTO]) |-> $past(aud_ret_exp);
  endproperty
  a_to_main: assert property (p_to_main) else $error("audio returned unqualified");

  property p_rf_dly_range;
    in_range(rf_dly_r, xfer_pkg::RF_DLY_MIN, xfer_pkg::DLY_MAX);
  endproperty
  a_rf_dly_range: assert property (p_rf_dly_range) else $error("rf delay out of range");

  property p_aud_dly_range;
    in_range(aud_chg_dly_r, xfer_pkg::AUD_DLY_MIN, xfer_pkg::DLY_MAX);
  endproperty
  a_aud_dly_range: assert property (p_aud_dly_range) else $error("audio delay out of range");

  property p_levels;
    ret_lvl_r <= chg_lvl_r;
  endproperty
  a_levels: assert property (p_levels) else $error("return level below changeover level");

  c_backup: cover property ($rose(aud_r));
  c_rf_xfer: cover property ($rose(xfer_r));
  c_maint_on: cover property (ctrl_r[xfer_pkg::CTRL_MAINT] && !tx1_mute_r && !tx2_mute_r);
endmodule // transmitter_transfer_control
`default_nettype wire

// ===== testbench/tx_pair_model.sv
`timescale 1ns/1ps
`default_nettype none
module tx_pair_model #(
  parameter bit LOCAL_RF_ON = 1'b1
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // mute commands from the controller
  input wire logic tx1_mute,
  input wire logic tx2_mute,
  // rf present at each transmitter output
  output logic tx1_rf_out,
  output logic tx2_rf_out
);
  logic tx1_rf_r;
  logic tx2_rf_r;
  logic tx1_rf_nxt;
  logic tx2_rf_nxt;
  // local rf on is left set, so the mute command alone decides
  always_comb
  begin
    tx1_rf_nxt = LOCAL_RF_ON & ~tx1_mute;
    tx2_rf_nxt = LOCAL_RF_ON & ~tx2_mute;
  end
  // one cycle of lag, a power stage never answers at once
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx1_rf_r <= 1'b0;
      tx2_rf_r <= 1'b0;
    end
    else
    begin
      tx1_rf_r <= tx1_rf_nxt;
      tx2_rf_r <= tx2_rf_nxt;
    end
  end
  assign tx1_rf_out = tx1_rf_r;
  assign tx2_rf_out = tx2_rf_r;
endmodule // tx_pair_model
`default_nettype wire

// ===== testbench/test_transmitter_transfer_control.sv
`timescale 1ns/1ps
`default_nettype none
module test_transmitter_transfer_control;
  // clock, reset and bus
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  // panel and field inputs
  logic btn_audio_auto = 1'b0;
  logic btn_audio_manual = 1'b0;
  logic btn_rf_on = 1'b0;
  logic btn_rf_off = 1'b0;
  logic [9:0] main_audio_atten = 10'h1c2;
  logic main_rf_low = 1'b0;
  logic sys_interlock_ok = 1'b1;
  logic dummy_interlock_ok = 1'b1;
  // outputs
  logic tx1_mute;
  logic tx2_mute;
  logic audio_backup_sel;
  logic irq;
  logic tx1_rf_out;
  logic tx2_rf_out;
  int error_cnt = 0;
  int total_checks = 0;
  logic [31:0] rd;
  logic err;

  transmitter_transfer_control #(.TICK_CYCLES(4)) u_transmitter_transfer_control (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .btn_audio_auto(btn_audio_auto), .btn_audio_manual(btn_audio_manual),
    .btn_rf_on(btn_rf_on), .btn_rf_off(btn_rf_off), .main_audio_atten(main_audio_atten),
    .main_rf_low(main_rf_low), .sys_interlock_ok(sys_interlock_ok),
    .dummy_interlock_ok(dummy_interlock_ok), .tx1_mute(tx1_mute), .tx2_mute(tx2_mute),
    .audio_backup_sel(audio_backup_sel), .irq(irq));
  tx_pair_model u_tx_pair_model (.pclk(pclk), .presetn(presetn), .tx1_mute(tx1_mute),
    .tx2_mute(tx2_mute), .tx1_rf_out(tx1_rf_out), .tx2_rf_out(tx2_rf_out));

  // 20 mhz clock
  initial
  begin
    forever #25 pclk = ~pclk;
  end

  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // one apb transfer, entered right after a rising edge; idles a cycle after
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    if (pready !== 1'b1)
      chk("pready", {31'h0, pready}, 32'h1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, rd, exp);
  endtask

  // button pulse one cycle wide, then two quiet edges so the mutes have settled
  task automatic press(input int b);
    case (b)
      0: btn_audio_auto <= 1'b1;
      1: btn_audio_manual <= 1'b1;
      2: btn_rf_on <= 1'b1;
      default: btn_rf_off <= 1'b1;
    endcase
    @(posedge pclk);
    {btn_audio_auto, btn_audio_manual, btn_rf_on, btn_rf_off} <= 4'h0;
    @(posedge pclk);
    @(posedge pclk);
  endtask

  task automatic wait_bs(input logic v, input int max);
    int n;
    n = 0;
    while (audio_backup_sel !== v && n < max)
    begin
      @(posedge pclk);
      n++;
    end
  endtask

  task automatic t_reset;
    chk("reset outs", {29'h0, audio_backup_sel, irq, pready}, 32'h0);
    rdchk("ctrl", xfer_pkg::OFF_CTRL, 32'h11);
    rdchk("aud_chg_dly", xfer_pkg::OFF_AUD_CHG_DLY, 32'hbb8);
    rdchk("aud_ret_dly", xfer_pkg::OFF_AUD_RET_DLY, 32'hbb8);
    rdchk("chg_lvl", xfer_pkg::OFF_AUD_CHG_LVL, 32'h258);
    rdchk("ret_lvl", xfer_pkg::OFF_AUD_RET_LVL, 32'h258);
    rdchk("rf_dly", xfer_pkg::OFF_RF_CHG_DLY, 32'hbb8);
    rdchk("irq_mask", xfer_pkg::OFF_IRQ_MASK, 32'h0);
    apb(1'b0, 8'h24, 32'h0);
    chk("unmapped err", {31'h0, err}, 32'h1);
    chk("unmapped data", rd, 32'h0);
    chk("muted", {30'h0, tx1_mute, tx2_mute}, 32'h3);
  endtask

  task automatic t_rf_ctrl;
    press(2);
    chk("mutes rf on", {30'h0, tx1_mute, tx2_mute}, 32'h1);
    rdchk("ctrl rf on", xfer_pkg::OFF_CTRL, 32'h19);
    chk("rf outs", {30'h0, tx1_rf_out, tx2_rf_out}, 32'h2);
    wr(xfer_pkg::OFF_CTRL, 32'h1d);
    cyc(2);
    chk("maint standby", {31'h0, tx2_mute}, 32'h0);
    dummy_interlock_ok <= 1'b0;
    cyc(3);
    chk("dummy il open", {31'h0, tx2_mute}, 32'h1);
    dummy_interlock_ok <= 1'b1;
    sys_interlock_ok <= 1'b0;
    cyc(3);
    chk("sys il open", {31'h0, tx2_mute}, 32'h1);
    sys_interlock_ok <= 1'b1;
    cyc(3);
    press(3);
    chk("mutes rf off", {30'h0, tx1_mute, tx2_mute}, 32'h3);
    rdchk("ctrl rf off", xfer_pkg::OFF_CTRL, 32'h15);
  endtask

  task automatic t_rejects;
    wr(xfer_pkg::OFF_RF_CHG_DLY, 32'h45);
    rdchk("rf dly low", xfer_pkg::OFF_RF_CHG_DLY, 32'hbb8);
    rdchk("irq reject", xfer_pkg::OFF_IRQ_STAT, 32'h8);
    chk("irq masked", {31'h0, irq}, 32'h0);
    wr(xfer_pkg::OFF_IRQ_STAT, 32'h8);
    rdchk("irq w1c", xfer_pkg::OFF_IRQ_STAT, 32'h0);
    wr(xfer_pkg::OFF_AUD_CHG_DLY, 32'h0);
    rdchk("aud dly zero", xfer_pkg::OFF_AUD_CHG_DLY, 32'hbb8);
    wr(xfer_pkg::OFF_AUD_CHG_DLY, 32'hbb9);
    rdchk("aud dly high", xfer_pkg::OFF_AUD_CHG_DLY, 32'hbb8);
    wr(xfer_pkg::OFF_AUD_RET_LVL, 32'h12c);
    wr(xfer_pkg::OFF_AUD_CHG_LVL, 32'h12b);
    rdchk("chg lvl below ret", xfer_pkg::OFF_AUD_CHG_LVL, 32'h258);
    wr(xfer_pkg::OFF_AUD_RET_LVL, 32'h259);
    rdchk("ret lvl above chg", xfer_pkg::OFF_AUD_RET_LVL, 32'h12c);
    wr(xfer_pkg::OFF_RF_CHG_DLY, 32'h46);
    rdchk("rf dly min", xfer_pkg::OFF_RF_CHG_DLY, 32'h46);
    wr(xfer_pkg::OFF_IRQ_STAT, 32'hf);
  endtask

  task automatic t_audio_auto;
    wr(xfer_pkg::OFF_CTRL, 32'h11);
    wr(xfer_pkg::OFF_AUD_CHG_DLY, 32'h3);
    wr(xfer_pkg::OFF_AUD_RET_DLY, 32'h3);
    wr(xfer_pkg::OFF_IRQ_MASK, 32'h3);
    main_audio_atten <= 10'h2bc;
    cyc(6);
    main_audio_atten <= 10'h1c2;
    cyc(3);
    main_audio_atten <= 10'h2bc;
    cyc(6);
    chk("restart", {31'h0, audio_backup_sel}, 32'h0);
    wait_bs(1'b1, 40);
    chk("to backup", {31'h0, audio_backup_sel}, 32'h1);
    cyc(2);
    chk("irq up", {31'h0, irq}, 32'h1);
    wr(xfer_pkg::OFF_IRQ_STAT, 32'h1);
    cyc(2);
    chk("irq cleared", {31'h0, irq}, 32'h0);
    main_audio_atten <= 10'h064;
    wait_bs(1'b0, 40);
    chk("to main", {31'h0, audio_backup_sel}, 32'h0);
    rdchk("irq main", xfer_pkg::OFF_IRQ_STAT, 32'h2);
    wr(xfer_pkg::OFF_IRQ_STAT, 32'h2);
  endtask

  task automatic t_manual;
    press(1);
    rdchk("ctrl manual", xfer_pkg::OFF_CTRL, 32'h10);
    main_audio_atten <= 10'h2bc;
    cyc(60);
    chk("no changeover", {31'h0, audio_backup_sel}, 32'h0);
    wr(xfer_pkg::OFF_CTRL, 32'h12);
    cyc(2);
    main_audio_atten <= 10'h064;
    cyc(60);
    chk("manual backup", {31'h0, audio_backup_sel}, 32'h1);
    press(0);
    rdchk("ctrl auto", xfer_pkg::OFF_CTRL, 32'h13);
  endtask

  task automatic t_rf_auto;
    main_audio_atten <= 10'h1c2;
    wr(xfer_pkg::OFF_CTRL, 32'h1d);
    main_rf_low <= 1'b1;
    cyc(400);
    chk("maint hold", {30'h0, tx1_mute, tx2_mute}, 32'h0);
    wr(xfer_pkg::OFF_CTRL, 32'h19);
    cyc(200);
    chk("before delay", {30'h0, tx1_mute, tx2_mute}, 32'h1);
    cyc(150);
    chk("transferred", {30'h0, tx1_mute, tx2_mute}, 32'h2);
    rdchk("irq rf", xfer_pkg::OFF_IRQ_STAT, 32'h4);
    apb(1'b0, xfer_pkg::OFF_STATUS, 32'h0);
    chk("status", rd & 32'h3e, 32'h36);
    // new active transmitter clears the transfer, timer then runs again
    wr(xfer_pkg::OFF_CTRL, 32'h39);
    cyc(2);
    chk("tx2 active", {30'h0, tx1_mute, tx2_mute}, 32'h2);
    cyc(350);
    chk("back to tx1", {30'h0, tx1_mute, tx2_mute}, 32'h1);
  endtask

  // watchdog at 10000 cycles, well past the roughly 1500 cycles of the run
  initial
  begin
    #500000;
    error_cnt++;
    final_report();
  end

  // main sequence
  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_rf_ctrl();
    t_rejects();
    t_audio_auto();
    t_manual();
    t_rf_auto();
    final_report();
  end
endmodule // test_transmitter_transfer_control
`default_nettype wire
